// File: rtl/host_port_pkg.sv
package host_port_pkg;
  // widths of the port and of a register word
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  // register select encodings
  localparam logic [1:0] SEL_CONTROL   = 2'h0;
  localparam logic [1:0] SEL_DATA_AUTO = 2'h1;
  localparam logic [1:0] SEL_ADDRESS   = 2'h2;
  localparam logic [1:0] SEL_DATA      = 2'h3;
  // halfword identifier values
  localparam logic HALF_FIRST  = 1'b0;
  localparam logic HALF_SECOND = 1'b1;
  // reset values and address step
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDRESS_STEP  = 32'h0000_0004;
  localparam logic [15:0] HALF_ZERO     = 16'h0000;
  // strobe timing, low and high pulse minimum of two cpu periods
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STROBE_MIN_NS  = 20;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host wait that covers the device's two-flop sampling and answer
  localparam int HOST_SETTLE_CYC = 8;
  localparam int FIFO_DEPTH      = 8;
  // device end states
  typedef enum logic [3:0] {
    D_IDLE  = 4'b0001,
    D_FETCH = 4'b0010,
    D_PUSH  = 4'b0100,
    D_INCR  = 4'b1000
  } dev_state_t;
  // host end states
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_LOW   = 4'b0100,
    H_HIGH  = 4'b1000
  } host_state_t;
endpackage : host_port_pkg

// File: rtl/host_port_if.sv
`timescale 1ns/1ps
interface host_port_if;
  logic        host_chip_select_n;
  logic        data_strobe_a;
  logic        data_strobe_b;
  logic        address_strobe_n;
  logic [1:0]  register_select;
  logic        read_not_write;
  logic        halfword_ident;
  logic [15:0] host_data_out;
  logic        host_data_oe_n;
  logic [15:0] dev_data_out;
  logic        dev_data_oe_n;
  logic        host_ready_n;
  logic [15:0] host_data_bus;

  // resolved level of the shared data bus, device wins a clash
  assign host_data_bus = !dev_data_oe_n  ? dev_data_out :
                         !host_data_oe_n ? host_data_out : 16'h0000;

  modport device (
    input  host_chip_select_n,
    input  data_strobe_a,
    input  data_strobe_b,
    input  address_strobe_n,
    input  register_select,
    input  read_not_write,
    input  halfword_ident,
    input  host_data_bus,
    output dev_data_out,
    output dev_data_oe_n,
    output host_ready_n
  );
  modport host (
    output host_chip_select_n,
    output data_strobe_a,
    output data_strobe_b,
    output address_strobe_n,
    output register_select,
    output read_not_write,
    output halfword_ident,
    output host_data_out,
    output host_data_oe_n,
    input  host_data_bus,
    input  host_ready_n
  );
endinterface : host_port_if

// File: rtl/sync_fifo.sv
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("sync_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + (AW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end
endmodule : sync_fifo

// File: rtl/host_port_device.sv
`timescale 1ns/1ps
module host_port_device
  import host_port_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  host_port_if.device      port,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic             rd_req,
  output logic [31:0]      rd_addr,
  input  wire logic        rd_ack,
  input  wire logic [31:0] rd_data,
  output logic [31:0]      control_word
);
  localparam int PIN_W = 24;

  if (FIFO_WORDS < 2) begin : g_chk
    $error("host_port_device needs a fifo of at least two words");
  end

  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic             cs_n_s;
  logic             strobe_n;
  logic             as_n_s;
  logic [1:0]       sel_s;
  logic             rnw_s;
  logic             hw_s;
  logic [15:0]      data_s;
  logic             strobe_prev_r;
  logic             as_prev_r;
  logic             strobe_fall;
  logic             strobe_rise;
  logic             as_seen_r;
  logic [1:0]       as_sel_r;
  logic             as_rnw_r;
  logic             as_hw_r;
  logic [1:0]       cur_sel;
  logic             cur_rnw;
  logic             cur_hw;
  logic [1:0]       acc_sel_r;
  logic             acc_rnw_r;
  logic             acc_hw_r;
  logic             acc_auto_r;
  dev_state_t       state_r;
  dev_state_t       state_nxt;
  logic [15:0]      wlow_r;
  logic [31:0]      word_in;
  logic [31:0]      ctrl_r;
  logic [31:0]      addr_r;
  logic [31:0]      data_r;
  logic [63:0]      push_data_r;
  logic             fifo_in_ready;
  logic [63:0]      fifo_out;
  logic             ready_n_r;
  logic [15:0]      dev_data_r;
  logic             dev_oe_n_r;
  logic             rd_req_r;
  logic [31:0]      rd_view;
  logic             second_end;

  // two-flop sampling of every pin from the host
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_s1_r <= {8'hFF, HALF_ZERO};
      pin_s2_r <= {8'hFF, HALF_ZERO};
    end else begin
      pin_s1_r <= {port.host_chip_select_n, port.data_strobe_a, port.data_strobe_b,
                   port.address_strobe_n, port.register_select, port.read_not_write,
                   port.halfword_ident, port.host_data_bus};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign cs_n_s   = pin_s2_r[23];
  assign as_n_s   = pin_s2_r[20];
  assign sel_s    = pin_s2_r[19:18];
  assign rnw_s    = pin_s2_r[17];
  assign hw_s     = pin_s2_r[16];
  assign data_s   = pin_s2_r[15:0];
  // combined strobe, low only while selected and strobes differ
  assign strobe_n = ~(pin_s2_r[22] ^ pin_s2_r[21]) | cs_n_s;

  // edge history of the strobes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobe_prev_r <= 1'b1;
      as_prev_r     <= 1'b1;
    end else begin
      strobe_prev_r <= strobe_n;
      as_prev_r     <= as_n_s;
    end
  end

  assign strobe_fall = strobe_prev_r && !strobe_n;
  assign strobe_rise = !strobe_prev_r && strobe_n;

  // selects latched by the address strobe when it is used
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      as_seen_r <= 1'b0;
      as_sel_r  <= SEL_CONTROL;
      as_rnw_r  <= 1'b1;
      as_hw_r   <= HALF_FIRST;
    end else if (as_prev_r && !as_n_s) begin
      as_seen_r <= 1'b1;
      as_sel_r  <= sel_s;
      as_rnw_r  <= rnw_s;
      as_hw_r   <= hw_s;
    end else if (strobe_rise) begin
      as_seen_r <= 1'b0;
    end
  end

  // selects in force at the falling combined strobe
  assign cur_sel = as_seen_r ? as_sel_r : sel_s;
  assign cur_rnw = as_seen_r ? as_rnw_r : rnw_s;
  assign cur_hw  = as_seen_r ? as_hw_r : hw_s;

  // access descriptor held for the whole strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_sel_r  <= SEL_CONTROL;
      acc_rnw_r  <= 1'b1;
      acc_hw_r   <= HALF_FIRST;
      acc_auto_r <= 1'b0;
    end else if (strobe_fall) begin
      acc_sel_r <= cur_sel;
      acc_rnw_r <= cur_rnw;
      acc_hw_r  <= cur_hw;
      if (cur_sel == SEL_DATA_AUTO || cur_sel == SEL_DATA) begin
        acc_auto_r <= (cur_sel == SEL_DATA_AUTO);
      end
    end
  end

  assign word_in    = {data_s, wlow_r};
  assign second_end = strobe_rise && (acc_hw_r == HALF_SECOND);

  // first halfword of a write kept until the second arrives
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wlow_r <= HALF_ZERO;
    end else if (strobe_rise && !acc_rnw_r && acc_hw_r == HALF_FIRST) begin
      wlow_r <= data_s;
    end
  end

  // completion sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      D_IDLE: begin
        if (strobe_fall && cur_rnw && cur_hw == HALF_FIRST &&
            (cur_sel == SEL_DATA || cur_sel == SEL_DATA_AUTO)) begin
          state_nxt = D_FETCH;
        end else if (second_end && !acc_rnw_r &&
                     (acc_sel_r == SEL_DATA || acc_sel_r == SEL_DATA_AUTO)) begin
          state_nxt = D_PUSH;
        end else if (second_end && acc_rnw_r && acc_sel_r == SEL_DATA_AUTO) begin
          state_nxt = D_INCR;
        end
      end
      D_FETCH: begin
        if (rd_ack) begin
          state_nxt = D_IDLE;
        end
      end
      D_PUSH: begin
        if (fifo_in_ready) begin
          state_nxt = D_IDLE;
        end
      end
      D_INCR:  state_nxt = D_IDLE;
      default: state_nxt = D_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= D_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // fetch request pulse toward the memory channel
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_req_r <= 1'b0;
    end else begin
      rd_req_r <= (state_r == D_IDLE) && (state_nxt == D_FETCH);
    end
  end

  // control and data registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r      <= CONTROL_RESET;
      data_r      <= '0;
      push_data_r <= '0;
    end else begin
      if (second_end && !acc_rnw_r && acc_sel_r == SEL_CONTROL) begin
        ctrl_r <= word_in;
      end
      if (state_r == D_FETCH && rd_ack) begin
        data_r <= rd_data;
      end else if (state_r == D_IDLE && state_nxt == D_PUSH) begin
        data_r      <= word_in;
        push_data_r <= {addr_r, word_in};
      end
    end
  end

  // address register with autoincrement after auto data traffic
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_r <= ADDRESS_RESET;
    end else if (second_end && !acc_rnw_r && acc_sel_r == SEL_ADDRESS) begin
      addr_r <= word_in;
    end else if (state_r == D_INCR ||
                 (state_r == D_PUSH && fifo_in_ready && acc_auto_r)) begin
      addr_r <= addr_r + ADDRESS_STEP;
    end
  end

  // busy only while a data transfer completes, and only when selected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready_n_r <= 1'b0;
    end else begin
      ready_n_r <= !cs_n_s && (state_nxt != D_IDLE || state_r == D_FETCH);
    end
  end

  // register view for a read halfword
  always_comb begin
    case (acc_sel_r)
      SEL_CONTROL: rd_view = ctrl_r;
      SEL_ADDRESS: rd_view = addr_r;
      default:     rd_view = data_r;
    endcase
  end

  // read data is set up before the ready that follows it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dev_data_r <= HALF_ZERO;
      dev_oe_n_r <= 1'b1;
    end else begin
      if (state_r == D_FETCH && rd_ack) begin
        dev_data_r <= rd_data[15:0];
      end else begin
        dev_data_r <= (acc_hw_r == HALF_FIRST) ? rd_view[15:0] : rd_view[31:16];
      end
      dev_oe_n_r <= !(!strobe_n && (strobe_fall ? cur_rnw : acc_rnw_r));
    end
  end

  sync_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_WORDS)
  ) u_wr_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (state_r == D_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_r),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  assign wr_addr            = fifo_out[63:32];
  assign wr_data            = fifo_out[31:0];
  assign rd_req             = rd_req_r;
  assign rd_addr            = addr_r;
  assign control_word       = ctrl_r;
  assign port.host_ready_n  = ready_n_r;
  assign port.dev_data_out  = dev_data_r;
  assign port.dev_data_oe_n = dev_oe_n_r;
endmodule : host_port_device

// File: rtl/host_port_host.sv
`timescale 1ns/1ps
module host_port_host
  import host_port_pkg::*;
#(
  parameter int SETTLE_CYC = HOST_SETTLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  host_port_if.host        port,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic [1:0]  cmd_sel,
  input  wire logic [31:0] cmd_wdata,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata
);
  if (SETTLE_CYC < STROBE_MIN_CYC || SETTLE_CYC > 255) begin : g_chk
    $error("host_port_host settle count out of range");
  end

  localparam logic [7:0] SETTLE = 8'(SETTLE_CYC);

  host_state_t state_r;
  logic [7:0]  cnt_r;
  logic [1:0]  rdy_s_r;
  logic [31:0] wdata_r;
  logic        cs_n_r;
  logic        strb_a_r;
  logic [1:0]  sel_r;
  logic        rnw_r;
  logic        hw_r;
  logic        oe_n_r;
  logic        ready_r;
  logic        rsp_r;
  logic [31:0] rdata_r;
  logic [15:0] dat_s1_r;
  logic [15:0] dat_s2_r;

  // two-flop sampling of ready and of the data bus
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdy_s_r  <= 2'b11;
      dat_s1_r <= HALF_ZERO;
      dat_s2_r <= HALF_ZERO;
    end else begin
      rdy_s_r  <= {rdy_s_r[0], port.host_ready_n};
      dat_s1_r <= port.host_data_bus;
      dat_s2_r <= dat_s1_r;
    end
  end

  // access sequencer, two halfwords per command, strobe via strobe a
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r  <= H_IDLE;
      cnt_r    <= '0;
      cs_n_r   <= 1'b1;
      strb_a_r <= 1'b1;
      sel_r    <= SEL_CONTROL;
      rnw_r    <= 1'b1;
      hw_r     <= HALF_FIRST;
      oe_n_r   <= 1'b1;
      wdata_r  <= '0;
      ready_r  <= 1'b0;
      rsp_r    <= 1'b0;
      rdata_r  <= '0;
    end else begin
      rsp_r <= 1'b0;
      cnt_r <= cnt_r + 8'd1;
      case (state_r)
        H_IDLE: begin
          ready_r <= 1'b1;
          if (cmd_valid && ready_r) begin
            ready_r <= 1'b0;
            wdata_r <= cmd_wdata;
            sel_r   <= cmd_sel;
            rnw_r   <= !cmd_write;
            hw_r    <= HALF_FIRST;
            oe_n_r  <= !cmd_write;
            cs_n_r  <= 1'b0;
            state_r <= H_SETUP;
          end
        end
        H_SETUP: begin
          strb_a_r <= 1'b0;
          cnt_r    <= '0;
          state_r  <= H_LOW;
        end
        H_LOW: begin
          if (cnt_r >= SETTLE && !rdy_s_r[1]) begin
            strb_a_r <= 1'b1;
            cnt_r    <= '0;
            state_r  <= H_HIGH;
            if (hw_r == HALF_FIRST) begin
              rdata_r[15:0] <= dat_s2_r;
            end else begin
              rdata_r[31:16] <= dat_s2_r;
            end
          end
        end
        H_HIGH: begin
          if (cnt_r >= SETTLE) begin
            cnt_r <= '0;
            if (hw_r == HALF_FIRST) begin
              hw_r     <= HALF_SECOND;
              strb_a_r <= 1'b0;
              state_r  <= H_LOW;
            end else begin
              cs_n_r  <= 1'b1;
              oe_n_r  <= 1'b1;
              rsp_r   <= 1'b1;
              state_r <= H_IDLE;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign cmd_ready               = ready_r;
  assign rsp_valid               = rsp_r;
  assign rsp_rdata               = rdata_r;
  assign port.host_chip_select_n = cs_n_r;
  assign port.data_strobe_a      = strb_a_r;
  assign port.data_strobe_b      = 1'b1;
  assign port.address_strobe_n   = 1'b1;
  assign port.register_select    = sel_r;
  assign port.read_not_write     = rnw_r;
  assign port.halfword_ident     = hw_r;
  assign port.host_data_out      = (hw_r == HALF_FIRST) ? wdata_r[15:0] : wdata_r[31:16];
  assign port.host_data_oe_n     = oe_n_r;
endmodule : host_port_host

// File: verification/host_port_props.sv
`timescale 1ns/1ps
module host_port_props
  import host_port_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       host_chip_select_n,
  input wire logic       data_strobe_a,
  input wire logic       data_strobe_b,
  input wire logic [1:0] register_select,
  input wire logic       read_not_write,
  input wire logic       halfword_ident,
  input wire logic       dev_data_oe_n,
  input wire logic       host_ready_n
);
  logic strobe_n;
  logic ctl_sel;
  logic busy_end;

  // combined strobe and the access kinds that matter for ready
  assign strobe_n = host_chip_select_n | (data_strobe_a == data_strobe_b);
  assign ctl_sel  = (register_select == SEL_CONTROL) | (register_select == SEL_ADDRESS);
  assign busy_end = (halfword_ident == HALF_SECOND) &
                    (read_not_write ? (register_select == SEL_DATA_AUTO) : register_select[0]);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_idle_ready;
    host_chip_select_n [*4] |-> !host_ready_n;
  endproperty
  property p_fetch_busy;
    $fell(strobe_n) && read_not_write && register_select[0] && (halfword_ident == HALF_FIRST)
      |-> ##[1:6] host_ready_n;
  endproperty
  property p_end_busy;
    $rose(strobe_n) && busy_end |-> ##[1:6] host_ready_n;
  endproperty
  property p_other_low;
    $rose(strobe_n) && !busy_end |-> !host_ready_n [*6];
  endproperty
  property p_ctl_keep;
    !strobe_n && ctl_sel && $past(!host_chip_select_n, 4) |-> !$rose(host_ready_n);
  endproperty
  property p_hold_rdy;
    $rose(strobe_n) |-> $past(!host_ready_n);
  endproperty
  property p_low_min;
    $fell(strobe_n) |=> !strobe_n;
  endproperty
  property p_high_min;
    $rose(strobe_n) |=> strobe_n;
  endproperty
  property p_oe_read;
    !dev_data_oe_n |-> read_not_write && !host_chip_select_n;
  endproperty
  property p_oe_off;
    strobe_n [*4] |-> dev_data_oe_n;
  endproperty
  property p_data_first;
    $fell(host_ready_n) && read_not_write && !strobe_n |-> $past(!dev_data_oe_n);
  endproperty

  a_idle_ready: assert property (p_idle_ready) else $error("ready not low while deselected");
  a_fetch_busy: assert property (p_fetch_busy) else $error("no busy on data read fetch");
  a_end_busy: assert property (p_end_busy) else $error("no busy after second halfword");
  a_other_low: assert property (p_other_low) else $error("ready left low state");
  a_ctl_keep: assert property (p_ctl_keep) else $error("register access moved ready");
  a_hold_rdy: assert property (p_hold_rdy) else $error("strobe released before ready");
  a_low_min: assert property (p_low_min) else $error("strobe low too short");
  a_high_min: assert property (p_high_min) else $error("strobe high too short");
  a_oe_read: assert property (p_oe_read) else $error("data bus driven outside read");
  a_oe_off: assert property (p_oe_off) else $error("data bus not released");
  a_data_first: assert property (p_data_first) else $error("ready before read data");

  // main scenarios reached
  c_fetch: cover property ($rose(host_ready_n) && read_not_write);
  c_write_end: cover property ($rose(strobe_n) && busy_end && !read_not_write);
  c_auto_read: cover property ($rose(strobe_n) && busy_end && read_not_write);
endmodule : host_port_props

// File: verification/tb.sv
`timescale 1ns/1ps
module tb
  import host_port_pkg::*;
;
  logic        sys_clk;
  logic        rst_n;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic [1:0]  cmd_sel;
  logic [31:0] cmd_wdata;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        wr_valid;
  logic        wr_ready;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic        rd_req;
  logic [31:0] rd_addr;
  logic        rd_ack;
  logic [31:0] rd_data;
  logic [31:0] control_word;
  logic [31:0] ctl;
  logic [31:0] cur;
  int          mismatches;
  int          n_tests;
  int          cycles;
  int          rd_lat;
  logic [63:0] got[$];
  logic [63:0] exp_q[$];

  host_port_if u_host_port_if ();

  host_port_host #(.SETTLE_CYC(6)) u_host_port_host (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .port      (u_host_port_if),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_write (cmd_write),
    .cmd_sel   (cmd_sel),
    .cmd_wdata (cmd_wdata),
    .rsp_valid (rsp_valid),
    .rsp_rdata (rsp_rdata)
  );

  host_port_device u_host_port_device (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .port         (u_host_port_if),
    .wr_valid     (wr_valid),
    .wr_ready     (wr_ready),
    .wr_addr      (wr_addr),
    .wr_data      (wr_data),
    .rd_req       (rd_req),
    .rd_addr      (rd_addr),
    .rd_ack       (rd_ack),
    .rd_data      (rd_data),
    .control_word (control_word)
  );

  host_port_props u_props (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .host_chip_select_n (u_host_port_if.host_chip_select_n),
    .data_strobe_a      (u_host_port_if.data_strobe_a),
    .data_strobe_b      (u_host_port_if.data_strobe_b),
    .register_select    (u_host_port_if.register_select),
    .read_not_write     (u_host_port_if.read_not_write),
    .halfword_ident     (u_host_port_if.halfword_ident),
    .dev_data_oe_n      (u_host_port_if.dev_data_oe_n),
    .host_ready_n       (u_host_port_if.host_ready_n)
  );

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // memory side answers fetches after rd_lat cycles
  initial begin
    rd_ack  = 1'b0;
    rd_data = 32'h0000_0000;
    forever begin
      @(posedge sys_clk);
      #1 rd_ack = 1'b0;
      if (rd_req === 1'b1) begin
        repeat (rd_lat) @(posedge sys_clk);
        #1 rd_ack = 1'b1;
        rd_data = rd_addr ^ 32'h5a5a_0000;
      end
    end
  end

  // collect words leaving the write buffer
  always @(negedge sys_clk) begin
    if (rst_n && wr_valid === 1'b1 && wr_ready) got.push_back({wr_addr, wr_data});
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one host command, with expectations from a model of the registers
  task automatic op(input logic w, input logic [1:0] s, input logic [31:0] d);
    logic [31:0] e;
    e = (s == SEL_CONTROL) ? ctl : (s == SEL_ADDRESS) ? cur : cur ^ 32'h5a5a_0000;
    @(posedge sys_clk);
    #1 cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1) begin @(posedge sys_clk); #1; end
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    if (w && s[0]) exp_q.push_back({cur, d});
    if (w && s == SEL_CONTROL) ctl = d;
    if (w && s == SEL_ADDRESS) cur = d;
    if (s == SEL_DATA_AUTO) cur = cur + ADDRESS_STEP;
    while (rsp_valid !== 1'b1) begin @(posedge sys_clk); #1; end
    if (!w) chk(rsp_rdata, e);
  endtask : op

  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    rd_lat = 1;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = 2'h0;
    cmd_wdata = 32'h0000_0000;
    wr_ready = 1'b1;
    ctl = CONTROL_RESET;
    cur = ADDRESS_RESET;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
    #1 chk(u_host_port_if.host_ready_n, 1'b0);
    chk(control_word, CONTROL_RESET);
    op(1'b1, SEL_CONTROL, 32'h1234_5678);
    chk(control_word, 32'h1234_5678);
    op(1'b0, SEL_CONTROL, 32'h0000_0000);
    op(1'b1, SEL_ADDRESS, 32'h0000_0100);
    chk(rd_addr, 32'h0000_0100);
    op(1'b0, SEL_ADDRESS, 32'h0000_0000);
    op(1'b1, SEL_DATA, 32'hcafe_0001);
    op(1'b1, SEL_DATA_AUTO, 32'hcafe_0002);
    op(1'b0, SEL_ADDRESS, 32'h0000_0000);
    op(1'b0, SEL_DATA, 32'h0000_0000);
    rd_lat = 25;
    op(1'b0, SEL_DATA_AUTO, 32'h0000_0000);
    rd_lat = 1;
    op(1'b0, SEL_ADDRESS, 32'h0000_0000);
    // fill the write buffer with the drain stalled plus one word, then one word more
    wr_ready = 1'b0;
    for (int i = 0; i < 9; i++) op(1'b1, SEL_DATA, 32'h0000_0090 + i);
    chk(wr_valid, 1'b1);
    fork
      op(1'b1, SEL_DATA, 32'h0000_0099);
      begin
        while (u_host_port_if.host_chip_select_n !== 1'b0) begin @(posedge sys_clk); #1; end
        repeat (5) @(posedge sys_clk);
        #1 chk(u_host_port_if.host_ready_n, 1'b1);
        repeat (20) @(posedge sys_clk);
        #1 wr_ready = 1'b1;
      end
    join
    repeat (20) @(posedge sys_clk);
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
    end_sim();
  end
endmodule : tb
